/* File: common/strap_pkg.sv */
// constants, field layout and register map of the power-up clock-ratio strap decoder
// Operation
// - platform clock also runs the core complex bus
// - core clock is derived from platform clock
// - straps 0-2 pick platform ratio 4,5,6
// - straps 3-5 pick core ratio 1 to 3
// - straps 7-8 pick memory ratio 8,10,12
// - memory clocking is asynchronous only
// - memory output clocks run half data rate
// - above 3:1 perfmon statistics not guaranteed
// - two-bit select picks io supply level
package strap_pkg;
	localparam int STRAP_W = 9;
	localparam int RATIO_W = 4;
	// strap positions, lowest index is the most significant code bit
	localparam int PLAT_POS = 0;
	localparam int PLAT_CW = 3;
	localparam int CORE_POS = 3;
	localparam int CORE_CW = 3;
	localparam int HICORE_POS = 6;
	localparam int DDR_POS = 7;
	localparam int DDR_CW = 2;
	// code windows and ratio mapping: ratio = base + step * (code - first)
	localparam int PLAT_FIRST = 0;
	localparam int PLAT_LAST = 2;
	localparam int PLAT_BASE = 4;
	localparam int PLAT_STEP = 1;
	// core ratio kept in half units so 1.5:1 and 2.5:1 stay exact
	localparam int CORE_FIRST = 2;
	localparam int CORE_LAST = 6;
	localparam int CORE_BASE = 2;
	localparam int CORE_STEP = 1;
	localparam int DDR_FIRST = 0;
	localparam int DDR_LAST = 2;
	localparam int DDR_BASE = 8;
	localparam int DDR_STEP = 2;
	localparam int PERFMON_LIMIT = 3;
	typedef enum logic [1:0] {IO_3V3, IO_2V5, IO_1V8} io_level_e;
	// register map, byte addresses
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_RATIOS = 4'h4;
	localparam logic [3:0] REG_CONTROL = 4'h8;
	localparam logic [3:0] REG_STRAPS = 4'hC;
	localparam logic [2:0] CONTROL_RESET = 3'h7;
	// status fields
	localparam int ST_CAPTURED = 0;
	localparam int ST_PLAT_ERR = 1;
	localparam int ST_CORE_ERR = 2;
	localparam int ST_DDR_ERR = 3;
	localparam int ST_PERFMON = 4;
	localparam int ST_CORE_SPD = 5;
	localparam int ST_PLAT_SPD = 6;
	localparam int ST_HICORE = 7;
	localparam int ST_PLL_EN = 8;
	// ratios fields
	localparam int RT_PLAT = 0;
	localparam int RT_CORE = 4;
	localparam int RT_DDR = 8;
	localparam int RT_MCK = 12;
	localparam int RT_IO = 16;
endpackage : strap_pkg

/* File: common/ratio_if.sv */
// carrier between a strap field and its ratio decoder
`timescale 1ns/1ps
interface ratio_if #(parameter int CW = 3);
	logic [CW-1:0] code;
	logic [strap_pkg::RATIO_W-1:0] ratio;
	logic valid;
	modport decoder (input code, output ratio, output valid);
	modport user (output code, input ratio, input valid);
endinterface : ratio_if

/* File: src/strap_field_decode.sv */
// maps one strap code window onto a clock ratio and flags reserved codes
`timescale 1ns/1ps
module strap_field_decode #(
	parameter int FIRST = 0,
	parameter int LAST = 2,
	parameter int BASE = 4,
	parameter int STEP = 1
) (
	// strap code in, ratio out
	ratio_if.decoder f
);
	import strap_pkg::*;
	wire in_window = (int'(f.code) >= FIRST) && (int'(f.code) <= LAST);
	wire [31:0] mapped = 32'(BASE + STEP * (int'(f.code) - FIRST));
	// reserved codes report ratio zero so nothing downstream can use them
	assign f.valid = in_window;
	assign f.ratio = in_window ? mapped[RATIO_W-1:0] : '0;
endmodule : strap_field_decode

/* File: src/reset_strap_clock_ratio_config.sv */
// power-up strap capture, clock ratio decode, pll start gating and wishbone status registers
`timescale 1ns/1ps
module reset_strap_clock_ratio_config #(
	parameter int ADR_W = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// wishbone slave
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	// board straps
	input wire logic [0:strap_pkg::STRAP_W-1] local_bus_addr_straps,
	input wire logic cfg_core_speed,
	input wire logic cfg_plat_speed,
	input wire logic [0:1] io_supply_level_select,
	// towards the plls
	output logic [strap_pkg::RATIO_W-1:0] platform_bus_ratio,
	output logic [strap_pkg::RATIO_W-1:0] core_ratio_half,
	output logic [strap_pkg::RATIO_W-1:0] ddr_ratio,
	output logic [strap_pkg::RATIO_W-1:0] mck_ratio,
	output logic plat_pll_en,
	output logic core_pll_en,
	output logic ddr_pll_en,
	output logic mem_async_mode,
	output logic core_speed_grade,
	output logic plat_speed_grade,
	output logic high_core_freq,
	output logic perfmon_unreliable,
	output logic config_error,
	output strap_pkg::io_level_e io_level
);
	import strap_pkg::*;

	logic captured_q;
	logic [0:STRAP_W-1] straps_q;
	logic core_spd_q;
	logic plat_spd_q;
	logic [0:1] vsel_q;
	logic out_valid_q;
	logic [2:0] ctrl_q;
	logic plat_err_q;
	logic core_err_q;
	logic ddr_err_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	ratio_if #(.CW(PLAT_CW)) plat_f ();
	ratio_if #(.CW(CORE_CW)) core_f ();
	ratio_if #(.CW(DDR_CW)) ddr_f ();

	// captured straps are the only source of every ratio
	assign plat_f.code = straps_q[PLAT_POS +: PLAT_CW];
	assign core_f.code = straps_q[CORE_POS +: CORE_CW];
	assign ddr_f.code = straps_q[DDR_POS +: DDR_CW];

	strap_field_decode #(.FIRST(PLAT_FIRST), .LAST(PLAT_LAST), .BASE(PLAT_BASE), .STEP(PLAT_STEP)) u_plat (
		.f(plat_f)
	);
	strap_field_decode #(.FIRST(CORE_FIRST), .LAST(CORE_LAST), .BASE(CORE_BASE), .STEP(CORE_STEP)) u_core (
		.f(core_f)
	);
	strap_field_decode #(.FIRST(DDR_FIRST), .LAST(DDR_LAST), .BASE(DDR_BASE), .STEP(DDR_STEP)) u_ddr (
		.f(ddr_f)
	);

	// sampled once at the first edge after release; later strap movement is ignored
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			captured_q <= 1'b0;
			straps_q <= '0;
			core_spd_q <= 1'b0;
			plat_spd_q <= 1'b0;
			vsel_q <= 2'h0;
		end
		else if (!captured_q)
		begin
			captured_q <= 1'b1;
			straps_q <= local_bus_addr_straps;
			core_spd_q <= cfg_core_speed;
			plat_spd_q <= cfg_plat_speed;
			vsel_q <= io_supply_level_select;
		end
	end

	// derived terms
	wire [7:0] plat_x3 = 8'(PERFMON_LIMIT) * {4'h0, plat_f.ratio};
	wire perfmon_d = {4'h0, ddr_f.ratio} > plat_x3;
	wire plat_en_d = plat_f.valid && ctrl_q[0];
	// core pll is fed from the platform clock, so it waits for the platform pll
	wire core_en_d = plat_en_d && core_f.valid && ctrl_q[1];
	wire ddr_en_d = ddr_f.valid && ctrl_q[2];
	wire [RATIO_W-1:0] mck_d = ddr_f.ratio >> 1;

	io_level_e io_level_d;
	assign io_level_d = (vsel_q == 2'h1) ? IO_2V5 : (vsel_q == 2'h2) ? IO_1V8 : IO_3V3;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_valid_q <= 1'b0;
			platform_bus_ratio <= '0;
			core_ratio_half <= '0;
			ddr_ratio <= '0;
			mck_ratio <= '0;
			plat_pll_en <= 1'b0;
			core_pll_en <= 1'b0;
			ddr_pll_en <= 1'b0;
			plat_err_q <= 1'b0;
			core_err_q <= 1'b0;
			ddr_err_q <= 1'b0;
			perfmon_unreliable <= 1'b0;
			io_level <= IO_3V3;
		end
		else if (captured_q)
		begin
			out_valid_q <= 1'b1;
			// one ratio serves both the platform and the core complex bus
			platform_bus_ratio <= plat_f.ratio;
			core_ratio_half <= core_f.ratio;
			ddr_ratio <= ddr_f.ratio;
			mck_ratio <= mck_d;
			plat_pll_en <= plat_en_d;
			core_pll_en <= core_en_d;
			ddr_pll_en <= ddr_en_d;
			plat_err_q <= !plat_f.valid;
			core_err_q <= !core_f.valid;
			ddr_err_q <= !ddr_f.valid;
			perfmon_unreliable <= perfmon_d;
			io_level <= io_level_d;
		end
	end

	// no synchronous memory mode exists
	assign mem_async_mode = 1'b1;
	assign core_speed_grade = core_spd_q;
	assign plat_speed_grade = plat_spd_q;
	assign high_core_freq = straps_q[HICORE_POS];
	assign config_error = plat_err_q || core_err_q || ddr_err_q;

	// wishbone decode
	wire wb_req = wb_cyc_i && wb_stb_i && !ack_q;
	wire [3:0] wb_addr = {wb_adr_i[3:2], 2'h0};
	wire hit_status = (wb_addr == REG_STATUS);
	wire hit_ratios = (wb_addr == REG_RATIOS);
	wire hit_control = (wb_addr == REG_CONTROL);
	wire hit_straps = (wb_addr == REG_STRAPS);
	wire ctrl_wr = wb_req && wb_we_i && hit_control && wb_sel_i[0];

	always_comb
	begin
		rdata_d = 32'h0;
		if (hit_status)
		begin
			rdata_d[ST_CAPTURED] = out_valid_q;
			rdata_d[ST_PLAT_ERR] = plat_err_q;
			rdata_d[ST_CORE_ERR] = core_err_q;
			rdata_d[ST_DDR_ERR] = ddr_err_q;
			rdata_d[ST_PERFMON] = perfmon_unreliable;
			rdata_d[ST_CORE_SPD] = core_spd_q;
			rdata_d[ST_PLAT_SPD] = plat_spd_q;
			rdata_d[ST_HICORE] = straps_q[HICORE_POS];
			rdata_d[ST_PLL_EN +: 3] = {ddr_pll_en, core_pll_en, plat_pll_en};
		end
		else if (hit_ratios)
		begin
			rdata_d[RT_PLAT +: RATIO_W] = platform_bus_ratio;
			rdata_d[RT_CORE +: RATIO_W] = core_ratio_half;
			rdata_d[RT_DDR +: RATIO_W] = ddr_ratio;
			rdata_d[RT_MCK +: RATIO_W] = mck_ratio;
			rdata_d[RT_IO +: 2] = io_level;
		end
		else if (hit_control)
		begin
			rdata_d[2:0] = ctrl_q;
		end
		else if (hit_straps)
		begin
			rdata_d[STRAP_W-1:0] = straps_q;
		end
	end

	// every access, mapped or not, is acked one cycle after it is seen
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
			ctrl_q <= CONTROL_RESET;
		end
		else
		begin
			ack_q <= wb_req;
			rdata_q <= wb_req ? rdata_d : 32'h0;
			if (ctrl_wr)
				ctrl_q <= wb_dat_i[2:0];
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_capture_once: assert property (captured_q |=> $stable(straps_q))
		else $error("straps changed after capture");
	a_plat_ratio_map: assert property (captured_q && plat_f.code == 3'h1 |=> platform_bus_ratio == 4'h5)
		else $error("platform code 001 not 5:1");
	a_core_ratio_map: assert property (captured_q && core_f.code == 3'h3 |=> core_ratio_half == 4'h3)
		else $error("core code 011 not 1.5:1");
	a_ddr_ratio_map: assert property (captured_q && ddr_f.code == 2'h2 |=> ddr_ratio == 4'hC)
		else $error("memory code 10 not 12:1");
	a_ddr_reserved: assert property (captured_q && ddr_f.code == 2'h3 |=> ddr_err_q && !ddr_pll_en)
		else $error("reserved memory code started pll");
	a_plat_reserved: assert property (out_valid_q && plat_err_q |-> !plat_pll_en && !core_pll_en)
		else $error("reserved platform code started pll");
	a_core_after_plat: assert property (core_pll_en |-> plat_pll_en)
		else $error("core pll without platform pll");
	a_mck_half_rate: assert property (out_valid_q |-> {mck_ratio, 1'b0} == {1'b0, ddr_ratio})
		else $error("output clock not half data rate");
	a_perfmon_flag: assert property (out_valid_q |-> perfmon_unreliable == (ddr_ratio > 3 * platform_bus_ratio))
		else $error("perfmon flag wrong");
	a_io_level_map: assert property (captured_q && vsel_q == 2'h2 |=> io_level == IO_1V8)
		else $error("select 10 not 1.8 V");
	a_async_only: assert property (mem_async_mode)
		else $error("memory left asynchronous mode");
	a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
endmodule : reset_strap_clock_ratio_config

/* File: verification/strap_board.sv */
// board strap model: resistors feeding the power-up configuration pins
`timescale 1ns/1ps
module strap_board (
	// configuration chosen by the bench
	input wire logic [8:0] cfg_word,
	input wire logic [1:0] vsel_cfg,
	input wire logic core_fast,
	input wire logic plat_fast,
	// pins towards the device
	output logic [0:8] straps,
	output logic core_spd,
	output logic plat_spd,
	output logic [0:1] vsel
);
	// resistors are static, so nothing moves while the device samples
	assign straps = cfg_word;
	assign core_spd = core_fast;
	assign plat_spd = plat_fast;
	assign vsel = vsel_cfg;
endmodule : strap_board

/* File: verification/reset_strap_clock_ratio_config_tb_top.sv */
// self-checking bench for the strap clock-ratio decoder
`timescale 1ns/1ps
module reset_strap_clock_ratio_config_tb_top;
	import strap_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [8:0] cfg_word = 9'h0;
	logic [1:0] vsel_cfg = 2'h0;
	logic core_fast = 1'b0;
	logic plat_fast = 1'b0;
	logic [0:8] local_bus_addr_straps;
	logic cfg_core_speed;
	logic cfg_plat_speed;
	logic [0:1] io_supply_level_select;
	logic [3:0] platform_bus_ratio, core_ratio_half, ddr_ratio, mck_ratio;
	logic plat_pll_en, core_pll_en, ddr_pll_en, mem_async_mode, core_speed_grade, plat_speed_grade;
	logic high_core_freq, perfmon_unreliable, config_error;
	io_level_e io_level;
	int fails = 0;
	int total_checks = 0;
	reset_strap_clock_ratio_config dut (.clk, .rst_n, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i,
		.wb_cyc_i, .wb_stb_i, .wb_ack_o, .local_bus_addr_straps, .cfg_core_speed, .cfg_plat_speed,
		.io_supply_level_select, .platform_bus_ratio, .core_ratio_half, .ddr_ratio, .mck_ratio, .plat_pll_en,
		.core_pll_en, .ddr_pll_en, .mem_async_mode, .core_speed_grade, .plat_speed_grade, .high_core_freq,
		.perfmon_unreliable, .config_error, .io_level);
	strap_board board (.cfg_word, .vsel_cfg, .core_fast, .plat_fast, .straps(local_bus_addr_straps),
		.core_spd(cfg_core_speed), .plat_spd(cfg_plat_speed), .vsel(io_supply_level_select));
	initial
	begin
		forever #20 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one classic cycle; waits up to 20 extra cycles for ack, then counts a failure
	task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= wd;
		wb_sel_i <= 4'hF;
		@(posedge clk);
		while (wb_ack_o !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge clk);
		end
		if (n == 20)
			fails++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb_xfer
	task automatic run_case(input int i);
		logic [2:0] pc, cc;
		logic [1:0] dc, io;
		logic [3:0] pe, ce, de;
		logic perf;
		logic [31:0] rd;
		pc = 3'(i);
		cc = 3'(6 - i);
		dc = 2'(i);
		io = (2'(i + 1) == 2'h3) ? 2'h0 : 2'(i + 1);
		pe = (pc <= 3'h2) ? 4'(4 + pc) : 4'h0;
		ce = (cc >= 3'h2 && cc <= 3'h6) ? 4'(cc) : 4'h0;
		de = (dc != 2'h3) ? 4'(8 + 2 * dc) : 4'h0;
		perf = int'(de) > 3 * int'(pe);
		@(posedge clk);
		rst_n <= 1'b0;
		cfg_word <= {pc, cc, i[0], dc};
		vsel_cfg <= 2'(i + 1);
		core_fast <= i[1];
		plat_fast <= i[2];
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// straps move after capture and must be ignored
		cfg_word <= ~cfg_word;
		repeat (2) @(posedge clk);
		check({platform_bus_ratio, core_ratio_half, ddr_ratio, mck_ratio}, {pe, ce, de, de >> 1});
		check({plat_pll_en, core_pll_en, ddr_pll_en, mem_async_mode, perfmon_unreliable, config_error, io_level,
			high_core_freq, core_speed_grade, plat_speed_grade}, {pe != 4'h0, ce != 4'h0 && pe != 4'h0,
			de != 4'h0, 1'b1, perf, pe == 4'h0 || ce == 4'h0 || de == 4'h0, io, i[0], i[1], i[2]});
		wb_xfer(1'b1, REG_RATIOS, 32'hFFFF_FFFF, rd);
		wb_xfer(1'b0, REG_RATIOS, 32'h0, rd);
		check(rd, {14'h0, io, de >> 1, de, ce, pe});
		wb_xfer(1'b0, REG_STATUS, 32'h0, rd);
		check(rd, {21'h0, de != 4'h0, ce != 4'h0 && pe != 4'h0, pe != 4'h0, i[0], i[2], i[1], perf,
			de == 4'h0, ce == 4'h0, pe == 4'h0, 1'b1});
		wb_xfer(1'b0, REG_STRAPS, 32'h0, rd);
		check(rd, {23'h0, pc, cc, i[0], dc});
		wb_xfer(1'b1, REG_CONTROL, 32'h0, rd);
		wb_xfer(1'b0, REG_CONTROL, 32'h0, rd);
		check(rd, 32'h0);
		check({29'h0, plat_pll_en, core_pll_en, ddr_pll_en}, 32'h0);
		$display("case %0d done", i);
	endtask : run_case
	// board setup inside every limit: 66.66 MHz reference, bus 267, core 533, data rate 800, memory clock 400
	task automatic run_legal;
		logic [31:0] rd;
		@(posedge clk);
		rst_n <= 1'b0;
		cfg_word <= 9'b000_100_1_10;
		vsel_cfg <= 2'h3;
		core_fast <= 1'b1;
		plat_fast <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		check({platform_bus_ratio, core_ratio_half, ddr_ratio, mck_ratio}, 32'h0000_44C6);
		check({plat_pll_en, core_pll_en, ddr_pll_en, mem_async_mode, perfmon_unreliable, config_error, io_level,
			high_core_freq, core_speed_grade, plat_speed_grade}, {4'hF, 2'h0, IO_3V3, 3'b110});
		wb_xfer(1'b0, REG_CONTROL, 32'h0, rd);
		check(rd, {29'h0, CONTROL_RESET});
		// core pll held off alone; it must stay off while the other two run
		wb_xfer(1'b1, REG_CONTROL, 32'h5, rd);
		@(posedge clk);
		check({29'h0, plat_pll_en, core_pll_en, ddr_pll_en}, 32'h5);
		$display("legal case done");
	endtask : run_legal
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		for (int i = 0; i < 8; i++)
			run_case(i);
		run_legal;
		report_and_stop;
	end
	initial
	begin
		#(40 * 5000);
		fails++;
		report_and_stop;
	end
endmodule : reset_strap_clock_ratio_config_tb_top
